// *** rtl/simd_fp_exc_pkg.sv ***
package simd_fp_exc_pkg;

    // register offsets (byte addresses on the plain register port)
    localparam logic [3:0]  CSR_OFS          = 4'h0;
    localparam logic [3:0]  OS_CTRL_OFS      = 4'h4;

    // control/status layout: flags in 5:0, masks in 12:7
    localparam int          FLAG_LSB         = 0;
    localparam int          MASK_LSB         = 7;
    localparam int          NUM_COND         = 6;
    localparam int          CSR_W            = 13;
    localparam int          OS_SUPPORT_BIT   = 10;

    // reset values: all conditions masked, no flags, no os support
    localparam logic [12:0] CSR_RST          = 13'h1f80;
    localparam logic        OS_RST           = 1'b0;

    // condition bit numbers within the flag and mask fields
    localparam int          C_INVALID        = 0;
    localparam int          C_DENORMAL       = 1;
    localparam int          C_DIV_ZERO       = 2;
    localparam int          C_OVERFLOW       = 3;
    localparam int          C_UNDERFLOW      = 4;
    localparam int          C_INEXACT        = 5;

    // special encodings
    localparam logic [63:0] INDEF_D          = 64'hfff8000000000000;
    localparam logic [63:0] INDEF_S          = 64'h00000000ffc00000;
    localparam logic [63:0] INT_INDEF        = 64'h0000000080000000;
    localparam logic [63:0] QBIT_D           = 64'h0008000000000000;
    localparam logic [63:0] QBIT_S           = 64'h0000000000400000;
    localparam logic [63:0] ALL_ONES         = 64'hffffffffffffffff;

    // biased exponent at which |x| reaches 2^31
    localparam logic [10:0] INT_LIM_EXP_D    = 11'h41e;
    localparam logic [7:0]  INT_LIM_EXP_S    = 8'h9e;

    // compare predicates
    localparam logic [2:0]  PRED_LT          = 3'h1;
    localparam logic [2:0]  PRED_LE          = 3'h2;
    localparam logic [2:0]  PRED_UNORD       = 3'h3;
    localparam logic [2:0]  PRED_NEQ         = 3'h4;
    localparam logic [2:0]  PRED_NLT         = 3'h5;
    localparam logic [2:0]  PRED_NLE         = 3'h6;

    typedef enum logic [3:0] {
        op_add, op_sub, op_mul, op_div, op_sqrt, op_max, op_min,
        op_cmp, op_comi, op_cvt_s2d, op_cvt_d2s, op_cvt_int,
        op_x87_trunc_store
    } op_kind_t;

    typedef struct packed {
        op_kind_t    op;
        logic        dbl;
        logic [2:0]  pred;
        logic [63:0] src1;
        logic [63:0] src2;
        logic [63:0] dp_res;
        logic [4:0]  dp_cond;
    } req_t;

    typedef struct packed {
        logic        wr_dest;
        logic [63:0] result;
        logic        set_status;
        logic        zf;
        logic        pf;
        logic        cf;
    } resp_t;

endpackage

// *** rtl/simd_fp_exception_unit.sv ***
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/1ns
`default_nettype none

module simd_fp_exception_unit
    import simd_fp_exc_pkg::*;
#(
    parameter int ADDR_W = 4
)
(
    // clock and reset
    input  wire logic                  ref_clk_i,
    input  wire logic                  rst_n_i,

    // register port
    input  wire logic [ADDR_W-1:0]     reg_addr_i,
    input  wire logic [31:0]           reg_wdata_i,
    input  wire logic                  reg_wr_i,
    input  wire logic                  reg_rd_i,
    output var  logic [31:0]           reg_rdata_o,

    // instruction completing this cycle
    input  wire logic                  req_valid_i,
    input  wire simd_fp_exc_pkg::req_t req_i,

    // writeback and faults
    output var  logic                  resp_valid_o,
    output var  simd_fp_exc_pkg::resp_t resp_o,
    output var  logic                  simd_fp_fault_o,
    output var  logic                  invalid_opcode_fault_o
);

    // field helpers, shared by both sources
    function automatic logic fp_sign(input logic [63:0] v,
                                     input logic dbl);
        return dbl ? v[63] : v[31];
    endfunction

    function automatic logic exp_ones(input logic [63:0] v,
                                      input logic dbl);
        return dbl ? (&v[62:52]) : (&v[30:23]);
    endfunction

    function automatic logic frac_zero(input logic [63:0] v,
                                       input logic dbl);
        return dbl ? ~(|v[51:0]) : ~(|v[22:0]);
    endfunction

    function automatic logic is_nan(input logic [63:0] v,
                                    input logic dbl);
        return exp_ones(v, dbl) & ~frac_zero(v, dbl);
    endfunction

    // quiet bit clear marks a signalling NaN
    function automatic logic is_snan(input logic [63:0] v,
                                     input logic dbl);
        return is_nan(v, dbl) & ~(dbl ? v[51] : v[22]);
    endfunction

    function automatic logic is_inf(input logic [63:0] v,
                                    input logic dbl);
        return exp_ones(v, dbl) & frac_zero(v, dbl);
    endfunction

    function automatic logic is_zero(input logic [63:0] v,
                                     input logic dbl);
        return dbl ? ~(|v[62:0]) : ~(|v[30:0]);
    endfunction

    // software-visible state
    logic [CSR_W-1:0] csr_reg;
    logic [CSR_W-1:0] csr_next;
    logic             os_reg;
    logic             os_next;
    logic [31:0]      rdata_reg;
    logic [31:0]      rdata_next;

    // completion outputs
    logic             valid_reg;
    resp_t            resp_reg;
    resp_t            resp_next;
    logic             xf_reg;
    logic             xf_next;
    logic             ud_reg;
    logic             ud_next;

    // operand classification
    wire logic [63:0] a      = req_i.src1;
    wire logic [63:0] b      = req_i.src2;
    wire logic        dbl    = req_i.dbl;
    wire op_kind_t    op     = req_i.op;
    wire logic        nan_a  = is_nan(a, dbl);
    wire logic        nan_b  = is_nan(b, dbl);
    wire logic        snan_a = is_snan(a, dbl);
    wire logic        snan_b = is_snan(b, dbl);
    wire logic        any_nan  = nan_a | nan_b;
    wire logic        any_snan = snan_a | snan_b;
    wire logic        inf_a  = is_inf(a, dbl);
    wire logic        inf_b  = is_inf(b, dbl);
    wire logic        zero_a = is_zero(a, dbl);
    wire logic        zero_b = is_zero(b, dbl);
    wire logic        sgn_a  = fp_sign(a, dbl);
    wire logic        sgn_b  = fp_sign(b, dbl);

    // operation groups
    wire logic        is_addsub = (op == op_add) | (op == op_sub);
    wire logic        is_arith  = is_addsub | (op == op_mul)
                                | (op == op_div);
    wire logic        is_minmax = (op == op_max) | (op == op_min);
    wire logic        is_fcvt   = (op == op_cvt_s2d)
                                | (op == op_cvt_d2s);
    wire logic        is_trunc87 = (op == op_x87_trunc_store);

    // quieted first signalling NaN, in the source format
    wire logic [63:0] snan_src = snan_a ? a : b;
    wire logic [63:0] qnan_val = snan_src | (dbl ? QBIT_D : QBIT_S);
    wire logic [63:0] indef    = dbl ? INDEF_D : INDEF_S;

    // snan in add, sub, mul, div (addsub and horizontal map lane-wise)
    wire logic inv_arith_snan = is_arith & any_snan;

    // infinity cancellation: signs differ on add, agree on sub
    wire logic inv_inf_cancel = is_addsub & ~any_nan & inf_a & inf_b
                              & ((op == op_add) ? (sgn_a ^ sgn_b)
                                                : ~(sgn_a ^ sgn_b));

    wire logic inv_inf_zero = (op == op_mul) & ~any_nan
                            & ((inf_a & zero_b) | (zero_a & inf_b));

    wire logic inv_div = (op == op_div) & ~any_nan
                       & ((zero_a & zero_b) | (inf_a & inf_b));

    // square root looks at the first source only
    wire logic inv_sqrt_snan = (op == op_sqrt) & snan_a;
    wire logic inv_sqrt_neg  = (op == op_sqrt) & ~nan_a & sgn_a
                             & ~zero_a;

    wire logic inv_minmax = is_minmax & any_nan;

    // quiet NaN also trips the ordering predicates
    wire logic pred_ord = (req_i.pred == PRED_LT) | (req_i.pred == PRED_LE)
                        | (req_i.pred == PRED_NLT) | (req_i.pred == PRED_NLE);
    wire logic inv_cmp = (op == op_cmp)
                       & (any_snan | (any_nan & pred_ord));
    wire logic cmp_ones = (req_i.pred == PRED_NEQ)
                        | (req_i.pred == PRED_UNORD)
                        | (req_i.pred == PRED_NLT)
                        | (req_i.pred == PRED_NLE);

    wire logic inv_comi = (op == op_comi) & any_nan;

    wire logic inv_fcvt = is_fcvt & snan_a;

    // -2^31 itself is representable, everything at or past it is not
    wire logic int_min_exact = sgn_a & frac_zero(a, dbl)
                             & (dbl ? (a[62:52] == INT_LIM_EXP_D)
                                    : (a[30:23] == INT_LIM_EXP_S));
    wire logic int_over = dbl ? (a[62:52] >= INT_LIM_EXP_D)
                              : (a[30:23] >= INT_LIM_EXP_S);
    wire logic inv_cvt_int = (op == op_cvt_int)
                           & (nan_a | inf_a
                              | (int_over & ~int_min_exact));

    // converted quiet NaN in the destination format
    wire logic [63:0] cvt_qnan_d = {a[31], 11'h7ff, 1'b1,
                                    a[21:0], 29'h0};
    wire logic [63:0] cvt_qnan_s = {32'h0, a[63], 8'hff, 1'b1,
                                    a[50:29]};
    wire logic [63:0] cvt_qnan = (op == op_cvt_s2d) ? cvt_qnan_d
                                                     : cvt_qnan_s;

    // invalid condition, suppressed for the x87 truncating store
    wire logic inv_detect = ~is_trunc87
        & (inv_arith_snan | inv_inf_cancel | inv_inf_zero | inv_div
           | inv_sqrt_snan | inv_sqrt_neg | inv_minmax | inv_cmp
           | inv_comi | inv_fcvt | inv_cvt_int);

    // all six conditions of this instruction
    wire logic [NUM_COND-1:0] cond = req_valid_i & ~is_trunc87
        ? {req_i.dp_cond, inv_detect} : '0;

    wire logic [NUM_COND-1:0] flags = csr_reg[FLAG_LSB +: NUM_COND];
    wire logic [NUM_COND-1:0] masks = csr_reg[MASK_LSB +: NUM_COND];
    wire logic [NUM_COND-1:0] unmasked = cond & ~masks;
    wire logic                fault = |unmasked;

    // masked invalid value response, else the datapath result
    wire logic [63:0] inv_value =
          (inv_arith_snan | inv_sqrt_snan) ? qnan_val
        : (inv_sqrt_neg | inv_inf_cancel
           | inv_inf_zero | inv_div)       ? indef
        : inv_minmax                       ? b
        : inv_fcvt                         ? cvt_qnan
        : inv_cvt_int                      ? INT_INDEF
        :                                    req_i.dp_res;

    // compare mask follows the predicate whenever a NaN is present
    wire logic [63:0] cmp_value = (cmp_ones ? ALL_ONES : '0)
                                & (dbl ? ALL_ONES : 64'h00000000ffffffff);
    wire logic [63:0] result_val =
          ((op == op_cmp) & any_nan) ? cmp_value
        : inv_detect                 ? inv_value
        :                              req_i.dp_res;

    // on a fault the destination keeps its old contents
    always_comb
    begin
        resp_next            = '0;
        resp_next.wr_dest    = req_valid_i & ~fault
                             & (op != op_comi);
        resp_next.result     = result_val;
        resp_next.set_status = req_valid_i & ~fault & (op == op_comi);
        resp_next.zf         = inv_comi | req_i.dp_res[2];
        resp_next.pf         = inv_comi | req_i.dp_res[1];
        resp_next.cf         = inv_comi | req_i.dp_res[0];
    end

    // fault choice hangs on os support, taken at completion
    assign xf_next = fault & os_reg;
    assign ud_next = fault & ~os_reg;

    // register writes: detected conditions win over a same-cycle write
    wire logic csr_sel = (reg_addr_i == ADDR_W'(CSR_OFS));
    wire logic os_sel  = (reg_addr_i == ADDR_W'(OS_CTRL_OFS));
    wire logic [CSR_W-1:0] csr_wr_val = (reg_wr_i & csr_sel)
        ? reg_wdata_i[CSR_W-1:0] : csr_reg;
    wire logic [NUM_COND-1:0] set_flags = cond;

    // bits 0/7, 1/8, 2/9, 3/10, 4/11, 5/12 line up with cond order
    assign csr_next = csr_wr_val
        | (CSR_W'(set_flags) << FLAG_LSB);
    assign os_next  = (reg_wr_i & os_sel) ? reg_wdata_i[OS_SUPPORT_BIT]
                                          : os_reg;

    // read data valid the cycle after the strobe, zero elsewhere
    wire logic [31:0] csr_rd = {{(32-CSR_W){1'b0}}, csr_reg};
    wire logic [31:0] os_rd  = 32'(os_reg) << OS_SUPPORT_BIT;
    assign rdata_next = ~reg_rd_i ? 32'h0
                      : csr_sel   ? csr_rd
                      : os_sel    ? os_rd
                      :             32'h0;

    // architectural state
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            csr_reg <= CSR_RST;
            os_reg  <= OS_RST;
        end
        else
        begin
            csr_reg <= csr_next;
            os_reg  <= os_next;
        end
    end

    // completion and read pipeline, one stage
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            valid_reg <= 1'b0;
            resp_reg  <= '0;
            xf_reg    <= 1'b0;
            ud_reg    <= 1'b0;
            rdata_reg <= 32'h0;
        end
        else
        begin
            valid_reg <= req_valid_i;
            resp_reg  <= resp_next;
            xf_reg    <= xf_next;
            ud_reg    <= ud_next;
            rdata_reg <= rdata_next;
        end
    end

    // outputs straight from flops
    assign reg_rdata_o            = rdata_reg;
    assign resp_valid_o           = valid_reg;
    assign resp_o                 = resp_reg;
    assign simd_fp_fault_o        = xf_reg;
    assign invalid_opcode_fault_o = ud_reg;

endmodule

`default_nettype wire

// *** verification/simd_fp_exc_chk.sv ***
`timescale 1ns/1ns
`default_nettype none
module simd_fp_exc_chk
    import simd_fp_exc_pkg::*;
#(
    parameter int ADDR_W = 4
)
(
    // clock and reset
    input wire logic                   ref_clk_i,
    input wire logic                   rst_n_i,
    // register port
    input wire logic [ADDR_W-1:0]      reg_addr_i,
    input wire logic [31:0]            reg_wdata_i,
    input wire logic                   reg_wr_i,
    input wire logic                   reg_rd_i,
    input wire logic [31:0]            reg_rdata_o,
    // instruction path
    input wire logic                   req_valid_i,
    input wire simd_fp_exc_pkg::req_t  req_i,
    input wire logic                   resp_valid_o,
    input wire simd_fp_exc_pkg::resp_t resp_o,
    input wire logic                   simd_fp_fault_o,
    input wire logic                   invalid_opcode_fault_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    // normal negative single, neither zero, denormal nor nan
    sequence s_neg_sqrt;
        req_valid_i && req_i.op == op_sqrt && !req_i.dbl && req_i.src1[31]
            && req_i.src1[30:23] != 8'h00 && req_i.src1[30:23] != 8'hff;
    endsequence
    sequence s_comi_qnan;
        req_valid_i && req_i.op == op_comi && !req_i.dbl
            && req_i.src1[30:22] == 9'h1ff;
    endsequence

    resp_timing_a: assert property (resp_valid_o == $past(req_valid_i))
        else $error("response not one cycle after request");
    fault_cause_a: assert property (
        (simd_fp_fault_o || invalid_opcode_fault_o)
        |-> resp_valid_o && !resp_o.wr_dest && !resp_o.set_status)
        else $error("fault without response or with writeback");
    fault_excl_a: assert property (
        !(simd_fp_fault_o && invalid_opcode_fault_o))
        else $error("both faults at once");
    dest_nofault_a: assert property (resp_o.wr_dest |-> resp_valid_o
        && !simd_fp_fault_o && !invalid_opcode_fault_o)
        else $error("destination written beside a fault");
    x87_quiet_a: assert property (
        req_valid_i && req_i.op == op_x87_trunc_store
        |=> !simd_fp_fault_o && !invalid_opcode_fault_o
            && resp_o.result == $past(req_i.dp_res))
        else $error("x87 store raised a fault or lost its result");
    rdata_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
        else $error("read data outside the read cycle");
    comi_nan_a: assert property (s_comi_qnan |=> simd_fp_fault_o
        || invalid_opcode_fault_o || (resp_o.set_status && resp_o.zf
            && resp_o.pf && resp_o.cf))
        else $error("ordered compare with nan not unordered");
    sqrt_neg_a: assert property (s_neg_sqrt |=> simd_fp_fault_o
        || invalid_opcode_fault_o || resp_o.result == INDEF_S)
        else $error("square root of negative not indefinite");
endmodule
bind simd_fp_exception_unit simd_fp_exc_chk #(.ADDR_W(ADDR_W)) i_chk (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .req_valid_i(req_valid_i), .req_i(req_i),
    .resp_valid_o(resp_valid_o), .resp_o(resp_o),
    .simd_fp_fault_o(simd_fp_fault_o),
    .invalid_opcode_fault_o(invalid_opcode_fault_o));
`default_nettype wire

// *** verification/tb_simd_fp_exception_unit.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_simd_fp_exception_unit;
    import simd_fp_exc_pkg::*;
    logic        ref_clk_i;
    logic        rst_n_i;
    logic [3:0]  reg_addr_i;
    logic [31:0] reg_wdata_i;
    logic        reg_wr_i;
    logic        reg_rd_i;
    logic [31:0] reg_rdata_o;
    logic        req_valid_i;
    req_t        req_i;
    logic        resp_valid_o;
    resp_t       resp_o;
    logic        simd_fp_fault_o;
    logic        invalid_opcode_fault_o;
    int          n_fail;
    int          check_count;

    simd_fp_exception_unit #(.ADDR_W(4)) i_dut (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .req_valid_i(req_valid_i), .req_i(req_i),
        .resp_valid_o(resp_valid_o), .resp_o(resp_o),
        .simd_fp_fault_o(simd_fp_fault_o),
        .invalid_opcode_fault_o(invalid_opcode_fault_o));

    // 50 MHz clock
    initial
    begin
        ref_clk_i = 1'b0;
        forever #10 ref_clk_i = ~ref_clk_i;
    end

    task automatic stop_test;
        $display("checks %0d errors %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
    endtask

    // data stands only in the cycle after the read strobe
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
        #1;
        chk({32'h0, reg_rdata_o}, {32'h0, exp});
    endtask

    task automatic issue(input op_kind_t op, input logic [2:0] pr,
        input logic [63:0] s1, input logic [63:0] s2, input logic [4:0] cd);
        @(posedge ref_clk_i);
        req_valid_i <= 1'b1;
        req_i <= '{op, 1'b0, pr, s1, s2, 64'h5a5a, cd};
        @(posedge ref_clk_i);
        req_valid_i <= 1'b0;
        #1;
        chk({63'h0, resp_valid_o}, 64'h1);
    endtask

    // masked invalid: value written, no fault
    task automatic op_chk(input op_kind_t op, input logic [2:0] pr,
        input logic [63:0] s1, input logic [63:0] s2, input logic [63:0] e);
        issue(op, pr, s1, s2, 5'h0);
        chk(resp_o.result, e);
        chk({61'h0, resp_o.wr_dest, simd_fp_fault_o, invalid_opcode_fault_o},
            64'h4);
    endtask

    task automatic t_reset;
        rd(4'h0, 32'h1f80);
        rd(4'h4, 32'h0);
        rd(4'h8, 32'h0);
    endtask

    task automatic t_masked;
        op_chk(op_add, 3'h0, 64'h7f800001, 64'h3f800000, 64'h7fc00001);
        op_chk(op_sqrt, 3'h0, 64'h7f800001, 64'h0, 64'h7fc00001);
        op_chk(op_sqrt, 3'h0, 64'hbf800000, 64'h0, INDEF_S);
        op_chk(op_max, 3'h0, 64'h7fc00000, 64'h3f800000, 64'h3f800000);
        op_chk(op_min, 3'h0, 64'h3f800000, 64'hffc00001, 64'hffc00001);
        op_chk(op_cvt_s2d, 3'h0, 64'h7f800001, 64'h0,
            64'h7ff8000020000000);
        op_chk(op_add, 3'h0, 64'h7f800000, 64'hff800000, INDEF_S);
        op_chk(op_sub, 3'h0, 64'h7f800000, 64'h7f800000, INDEF_S);
        op_chk(op_mul, 3'h0, 64'h7f800000, 64'h0, INDEF_S);
        op_chk(op_div, 3'h0, 64'h0, 64'h0, INDEF_S);
        op_chk(op_div, 3'h0, 64'h7f800000, 64'h7f800000, INDEF_S);
        op_chk(op_cvt_int, 3'h0, 64'h7f800000, 64'h0, INT_INDEF);
        op_chk(op_cvt_int, 3'h0, 64'h4f000000, 64'h0, INT_INDEF);
        rd(4'h0, 32'h1f81);
        wr(4'h0, 32'h1f80);
        rd(4'h0, 32'h1f80);
    endtask

    task automatic t_compare;
        logic [63:0] e;
        for (int p = 0; p < 7; p++)
        begin
            e = (p inside {PRED_UNORD, PRED_NEQ, PRED_NLT, PRED_NLE})
                ? 64'hffffffff : 64'h0;
            op_chk(op_cmp, p[2:0], 64'h7fc00000, 64'h3f800000, e);
        end
        rd(4'h0, 32'h1f81);
        wr(4'h0, 32'h1f80);
        op_chk(op_add, 3'h0, 64'h7fc00000, 64'h3f800000, 64'h5a5a);
        rd(4'h0, 32'h1f80);
        issue(op_comi, 3'h0, 64'h7fc00000, 64'h3f800000, 5'h0);
        chk({resp_o.set_status, resp_o.zf, resp_o.pf, resp_o.cf}, 64'hf);
    endtask

    // unmasked: no writeback, fault chosen by the os bit
    task automatic t_unmasked;
        logic [31:0] m;
        wr(4'h0, 32'h1f00);
        issue(op_sqrt, 3'h0, 64'hbf800000, 64'h0, 5'h0);
        chk({simd_fp_fault_o, invalid_opcode_fault_o, resp_o.wr_dest}, 64'h2);
        wr(4'h4, 32'h400);
        rd(4'h4, 32'h400);
        issue(op_sqrt, 3'h0, 64'hbf800000, 64'h0, 5'h0);
        chk({simd_fp_fault_o, invalid_opcode_fault_o, resp_o.wr_dest}, 64'h4);
        for (int c = 1; c < 6; c++)
        begin
            m = 32'h1f80 & ~(32'h1 << (7 + c));
            wr(4'h0, m);
            issue(op_add, 3'h0, 64'h3f800000, 64'h3f800000, 5'h1 << (c - 1));
            chk({63'h0, simd_fp_fault_o}, 64'h1);
            rd(4'h0, m | (32'h1 << c));
        end
    endtask

    task automatic t_x87;
        wr(4'h0, 32'h0);
        issue(op_x87_trunc_store, 3'h0, 64'h7f800001, 64'h0, 5'h1f);
        chk({62'h0, simd_fp_fault_o, invalid_opcode_fault_o}, 64'h0);
        chk(resp_o.result, 64'h5a5a);
        rd(4'h0, 32'h0);
    endtask

    // hang guard
    initial
    begin
        repeat (20000) @(posedge ref_clk_i);
        n_fail++;
        stop_test;
    end

    initial
    begin
        n_fail = 0;
        check_count = 0;
        rst_n_i = 1'b0;
        reg_addr_i = 4'h0;
        reg_wdata_i = 32'h0;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        req_valid_i = 1'b0;
        req_i = '0;
        repeat (6) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        t_reset;
        t_masked;
        t_compare;
        t_unmasked;
        t_x87;
        stop_test;
    end
endmodule
`default_nettype wire
